// >>> design/arsm_pkg.sv
package arsm_pkg;
  // Register map
  localparam logic [7:0] ADDR_PIN_SEL = 8'h27;
  localparam logic [7:0] ADDR_CHAN1 = 8'h28;
  localparam logic [7:0] ADDR_CHAN2 = 8'h29;
  localparam logic [7:0] ADDR_CHAN3 = 8'h2a;
  localparam logic [7:0] RST_PIN_SEL = 8'h00;
  localparam logic [7:0] RST_CHAN1 = 8'h20;
  localparam logic [7:0] RST_CHAN2 = 8'h21;
  localparam logic [7:0] RST_CHAN3 = 8'h02;
  // Field layout of a channel register
  localparam int ENABLE_BIT = 5;
  localparam int SLOT_MSB = 4;
  localparam int RIGHT_BIT = 4;
  localparam int NUM_CHAN = 3;
  localparam int SLOT_W = 5;
  localparam int WORD_W = 32;
  localparam int SYNC_STAGES = 3;
  typedef enum logic {ARSM_FMT_TDM, ARSM_FMT_I2S_LJ} arsm_fmt_t;
endpackage

// >>> design/arsm_cfg_if.sv
`timescale 1ns/1ns
interface arsm_cfg_if;
  logic [arsm_pkg::NUM_CHAN-1:0] enable;
  logic [arsm_pkg::NUM_CHAN-1:0] pin_sel;
  logic [arsm_pkg::NUM_CHAN*arsm_pkg::SLOT_W-1:0] slot_select;
  modport regs (output enable, output pin_sel, output slot_select);
  modport user (input enable, input pin_sel, input slot_select);
endinterface

// >>> design/arsm_regs.sv
`timescale 1ns/1ns
module arsm_regs
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Register port
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // Configuration out
  arsm_cfg_if.regs cfg
);
  logic [7:0] pin_sel_ff;
  logic [7:0] chan_ff [arsm_pkg::NUM_CHAN];
  logic [7:0] rst_val [arsm_pkg::NUM_CHAN];
  logic [7:0] addr_of [arsm_pkg::NUM_CHAN];
  logic [7:0] rd_mux;

  assign rst_val[0] = arsm_pkg::RST_CHAN1;
  assign rst_val[1] = arsm_pkg::RST_CHAN2;
  assign rst_val[2] = arsm_pkg::RST_CHAN3;
  assign addr_of[0] = arsm_pkg::ADDR_CHAN1;
  assign addr_of[1] = arsm_pkg::ADDR_CHAN2;
  assign addr_of[2] = arsm_pkg::ADDR_CHAN3;

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      pin_sel_ff <= arsm_pkg::RST_PIN_SEL;
    else if (reg_wr_i && reg_addr_i == arsm_pkg::ADDR_PIN_SEL)
      pin_sel_ff <= reg_wdata_i;
  end

  for (genvar c = 0; c < arsm_pkg::NUM_CHAN; c++)
  begin : g_chan
    always_ff @(posedge sys_clk_i)
    begin
      if (rst_i)
        chan_ff[c] <= rst_val[c]; // RQ5 RQ6 RQ7
      else if (reg_wr_i && reg_addr_i == addr_of[c])
        chan_ff[c] <= {2'h0, reg_wdata_i[5:0]}; // RQ8
    end
    assign cfg.enable[c] = chan_ff[c][arsm_pkg::ENABLE_BIT];
    assign cfg.pin_sel[c] = pin_sel_ff[c]; // RQ9
    assign cfg.slot_select[c*arsm_pkg::SLOT_W +: arsm_pkg::SLOT_W] = chan_ff[c][arsm_pkg::SLOT_MSB:0];
  end

  always_comb
  begin
    rd_mux = 8'h00;
    if (reg_addr_i == arsm_pkg::ADDR_PIN_SEL)
      rd_mux = pin_sel_ff;
    for (int i = 0; i < arsm_pkg::NUM_CHAN; i++)
      if (reg_addr_i == addr_of[i])
        rd_mux = chan_ff[i];
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      reg_rdata_o <= 8'h00;
    else
      reg_rdata_o <= rd_mux;
  end
endmodule

// >>> design/arsm_top.sv
`timescale 1ns/1ns
// How it works
// RQ1: Enable bit 5 low disables the channel; high feeds same-numbered playback channel.
// RQ2: Selector 0 to 15 picks TDM slot or left slot of that index.
// RQ3: Selector 16 to 31 picks TDM slot, or right slot index minus 16.
// RQ4: Middle selector values follow the same numbering, no gaps.
// RQ5: Channel one register at 0x28 resets to 0x20.
// RQ6: Channel two register at 0x29 resets to 0x21.
// RQ7: Channel three register at 0x2a resets to 0x02.
// RQ8: Software writes bits 7 and 6 as zero; they read zero.
// RQ9: Pin-select bit per channel picks primary or secondary data pin.
// RQ10: Disabled channel holds its output; enabled captures only its selected slot.
module arsm_top
#(
  parameter int WORD_W = arsm_pkg::WORD_W
)
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Register port
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // Serial link pins
  input wire logic bclk_i,
  input wire logic fsync_i,
  input wire logic primary_data_in_i,
  input wire logic secondary_data_in_pin_i,
  input wire logic format_i2s_lj_i,
  input wire logic [4:0] slot_width_m1_i,
  // Playback data
  output logic [arsm_pkg::NUM_CHAN*WORD_W-1:0] play_data_o,
  output logic [arsm_pkg::NUM_CHAN-1:0] play_valid_o
);
  arsm_cfg_if cfg ();

  arsm_regs u_regs
  (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .reg_wr_i(reg_wr_i),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o),
    .cfg(cfg)
  );

  // Three-stage synchronisers for pins
  logic [arsm_pkg::SYNC_STAGES-1:0] bclk_ff, fs_ff, din1_ff, secondary_data_in_pin_ff;
  logic bclk_d_ff, fs_d_ff, din1_d_ff, secondary_data_in_pin_d_ff;
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      bclk_ff <= 3'h0;
      fs_ff <= 3'h0;
      din1_ff <= 3'h0;
      secondary_data_in_pin_ff <= 3'h0;
    end
    else
    begin
      bclk_ff <= {bclk_ff[1:0], bclk_i};
      fs_ff <= {fs_ff[1:0], fsync_i};
      din1_ff <= {din1_ff[1:0], primary_data_in_i};
      secondary_data_in_pin_ff <= {secondary_data_in_pin_ff[1:0], secondary_data_in_pin_i};
    end
  end

  // Filtered levels: change once stages two and three agree
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      bclk_d_ff <= 1'b0;
      fs_d_ff <= 1'b0;
      din1_d_ff <= 1'b0;
      secondary_data_in_pin_d_ff <= 1'b0;
    end
    else
    begin
      if (bclk_ff[1] == bclk_ff[2])
        bclk_d_ff <= bclk_ff[2];
      if (fs_ff[1] == fs_ff[2])
        fs_d_ff <= fs_ff[2];
      if (din1_ff[1] == din1_ff[2])
        din1_d_ff <= din1_ff[2];
      if (secondary_data_in_pin_ff[1] == secondary_data_in_pin_ff[2])
        secondary_data_in_pin_d_ff <= secondary_data_in_pin_ff[2];
    end
  end

  logic bclk_prev_ff, fs_prev_ff;
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      bclk_prev_ff <= 1'b0;
    else
      bclk_prev_ff <= bclk_d_ff;
  end

  wire bclk_rise = bclk_d_ff && !bclk_prev_ff;
  wire fs_level_at_rise = fs_d_ff;

  // Frame sync level as seen at the previous bit clock rise
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      fs_prev_ff <= 1'b0;
    else if (bclk_rise)
      fs_prev_ff <= fs_level_at_rise;
  end

  wire fs_start = bclk_rise && fs_level_at_rise && !fs_prev_ff;
  // In I2S/LJ framing a falling frame sync opens the right half
  wire fs_right = bclk_rise && !fs_level_at_rise && fs_prev_ff;
  wire first_bit = fs_start || (fs_right && format_i2s_lj_i);

  // Slot and bit counters
  logic [4:0] bit_cnt_ff;
  logic [3:0] slot_cnt_ff;
  logic half_ff;
  logic [4:0] nxt_bit_cnt;
  logic [3:0] nxt_slot_cnt;
  logic nxt_half;
  wire last_bit = (bit_cnt_ff == slot_width_m1_i);
  always_comb
  begin
    nxt_bit_cnt = bit_cnt_ff;
    nxt_slot_cnt = slot_cnt_ff;
    nxt_half = half_ff;
    if (first_bit)
    begin
      nxt_bit_cnt = 5'h01;
      nxt_slot_cnt = 4'h0;
      nxt_half = fs_right;
    end
    else if (bclk_rise)
    begin
      nxt_bit_cnt = last_bit ? 5'h00 : bit_cnt_ff + 5'h01;
      if (last_bit)
      begin
        nxt_slot_cnt = slot_cnt_ff + 4'h1;
        // TDM slots 16 to 31 sit in the upper selector half
        if (!format_i2s_lj_i && slot_cnt_ff == 4'hf)
          nxt_half = !half_ff;
      end
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      bit_cnt_ff <= 5'h00;
      slot_cnt_ff <= 4'h0;
      half_ff <= 1'b0;
    end
    else
    begin
      bit_cnt_ff <= nxt_bit_cnt;
      slot_cnt_ff <= nxt_slot_cnt;
      half_ff <= nxt_half;
    end
  end

  // Current slot as a five-bit selector value
  wire [4:0] cur_slot = {half_ff, slot_cnt_ff}; // RQ2 RQ3 RQ4
  // Slot that the arriving bit belongs to
  wire [4:0] next_slot = first_bit ? {fs_right, 4'h0} : cur_slot; // RQ3

  for (genvar c = 0; c < arsm_pkg::NUM_CHAN; c++)
  begin : g_rx
    logic [WORD_W-1:0] sh_ff;
    logic [WORD_W-1:0] data_ff;
    logic valid_ff;
    logic [WORD_W-1:0] nxt_sh;
    logic [WORD_W-1:0] nxt_data;
    wire [4:0] sel = cfg.slot_select[c*arsm_pkg::SLOT_W +: arsm_pkg::SLOT_W];
    wire din = cfg.pin_sel[c] ? secondary_data_in_pin_d_ff : din1_d_ff; // RQ9
    wire next_match = (next_slot == sel);
    wire cur_match = (cur_slot == sel);
    wire hit = cfg.enable[c] && next_match; // RQ1 RQ2 RQ3
    wire done = bclk_rise && !first_bit && last_bit && cfg.enable[c] && cur_match;

    always_comb
    begin
      nxt_sh = sh_ff;
      nxt_data = data_ff;
      if (bclk_rise && hit)
        nxt_sh = {sh_ff[WORD_W-2:0], din};
      // Last bit joins the word directly, so it is whole at once
      if (done)
        nxt_data = {sh_ff[WORD_W-2:0], din}; // RQ1 RQ10
    end

    always_ff @(posedge sys_clk_i)
    begin
      if (rst_i)
        sh_ff <= '0;
      else
        sh_ff <= nxt_sh;
    end

    always_ff @(posedge sys_clk_i)
    begin
      if (rst_i)
      begin
        data_ff <= '0;
        valid_ff <= 1'b0;
      end
      else
      begin
        valid_ff <= done; // RQ10
        data_ff <= nxt_data;
      end
    end
    assign play_data_o[c*WORD_W +: WORD_W] = data_ff;
    assign play_valid_o[c] = valid_ff;
  end
endmodule

// >>> testbench/arsm_top_checker.sv
`timescale 1ns/1ns
module arsm_top_checker
#(
  parameter int WORD_W = 32
)
(
  // Clock, reset and register port
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  // Playback data
  input wire logic [3*WORD_W-1:0] play_data_o,
  input wire logic [2:0] play_valid_o
);
  logic [2:0] en_ff;
  wire ch_wr = reg_wr_i && reg_addr_i[7:2] == 6'h0a && reg_addr_i[1:0] != 2'h3;
  wire [7:0] rst_val = reg_addr_i == 8'h28 ? 8'h20 : reg_addr_i == 8'h29 ? 8'h21 : reg_addr_i == 8'h2a ? 8'h02 : 8'h00;
  // Shadow of the channel enables
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      en_ff <= 3'h3;
    else if (ch_wr)
      en_ff[reg_addr_i[1:0]] <= reg_wdata_i[5];
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  property p_rst_rd;
    $past(rst_i) && !reg_wr_i |=> reg_rdata_o == $past(rst_val);
  endproperty
  a_rst_rd: assert property (p_rst_rd) else $error("register reset value wrong");
  property p_wr_rd;
    ch_wr ##1 !reg_wr_i && $stable(reg_addr_i) |=> reg_rdata_o == {2'h0, $past(reg_wdata_i[5:0], 2)};
  endproperty
  a_wr_rd: assert property (p_wr_rd) else $error("channel register readback wrong");
  property p_pin_rd;
    reg_wr_i && reg_addr_i == 8'h27 ##1 !reg_wr_i && $stable(reg_addr_i) |=> reg_rdata_o == $past(reg_wdata_i, 2);
  endproperty
  a_pin_rd: assert property (p_pin_rd) else $error("pin select readback wrong");
  property p_unmap;
    !(reg_addr_i inside {[8'h27:8'h2a]}) |=> reg_rdata_o == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_dis;
    (play_valid_o & ~en_ff) == 3'h0;
  endproperty
  a_dis: assert property (p_dis) else $error("disabled channel pulsed");
  property p_pulse;
    play_valid_o != 3'h0 |=> (play_valid_o & $past(play_valid_o)) == 3'h0;
  endproperty
  a_pulse: assert property (p_pulse) else $error("valid longer than one cycle");
  property p_hold;
    play_valid_o == 3'h0 |-> $stable(play_data_o);
  endproperty
  a_hold: assert property (p_hold) else $error("data moved without valid");
  property p_out_rst;
    $past(rst_i) |-> play_valid_o == 3'h0 && play_data_o == '0;
  endproperty
  a_out_rst: assert property (p_out_rst) else $error("outputs not cleared by reset");
endmodule
bind arsm_top arsm_top_checker #(.WORD_W(WORD_W)) i_chk (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
  .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
  .play_data_o(play_data_o), .play_valid_o(play_valid_o));

// >>> testbench/arsm_src.sv
`timescale 1ns/1ns
module arsm_src
(
  // Bench clock
  input wire logic sys_clk_i,
  // Serial link pins
  output logic bclk_o,
  output logic fsync_o,
  output logic d0_o,
  output logic d1_o
);
  initial
    {bclk_o, fsync_o, d0_o, d1_o} = 4'h1;
  // Slot s carries word s on primary pin, its inverse on secondary
  task automatic frame(input logic i2s);
    for (int s = 0; s < 32; s++)
    begin
      for (int b = 4; b >= 0; b--)
      begin
        fsync_o <= i2s ? s < 16 : s == 0;
        d0_o <= s[b];
        d1_o <= !s[b];
        repeat (5) @(posedge sys_clk_i);
        bclk_o <= 1'b1;
        repeat (5) @(posedge sys_clk_i);
        bclk_o <= 1'b0;
      end
    end
    // Released lines do not keep the last bit
    fsync_o <= 1'b0;
    d0_o <= !d0_o;
    d1_o <= !d1_o;
  endtask
endmodule

// >>> testbench/arsm_top_tb.sv
`timescale 1ns/1ns
module arsm_top_tb;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic reg_wr_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h2a;
  logic [7:0] reg_wdata_i = 8'h00;
  logic fmt_ff = 1'b0;
  logic [7:0] reg_rdata_o;
  logic bclk, fsync, d0, d1;
  logic [14:0] play_data_o;
  logic [2:0] play_valid_o;
  int np[3] = '{0, 0, 0};
  int n_fail = 0;
  int check_count = 0;
  int cyc = 0;
  always #25 sys_clk_i = !sys_clk_i;
  arsm_src i_src (.sys_clk_i(sys_clk_i), .bclk_o(bclk), .fsync_o(fsync), .d0_o(d0), .d1_o(d1));
  arsm_top #(.WORD_W(5)) i_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_wr_i(reg_wr_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .bclk_i(bclk),
    .fsync_i(fsync), .primary_data_in_i(d0), .secondary_data_in_pin_i(d1), .format_i2s_lj_i(fmt_ff),
    .slot_width_m1_i(5'h04), .play_data_o(play_data_o), .play_valid_o(play_valid_o));
  task automatic end_of_test();
    $display("checks %0d fails %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(negedge sys_clk_i)
  begin
    cyc++;
    for (int k = 0; k < 3; k++)
      np[k] += int'(play_valid_o[k]);
    if (cyc == 40000)
    begin
      n_fail++;
      end_of_test();
    end
  end
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_addr_i <= a;
    @(posedge sys_clk_i);
    // Read data is looked at away from its launching edge
    @(negedge sys_clk_i);
    check(reg_rdata_o, e);
    @(posedge sys_clk_i);
  endtask
  task automatic run_frame(input logic [7:0] c1, c2, c3, pin, input logic i2s);
    logic [7:0] c[3];
    int base[3];
    logic [14:0] held;
    c = '{c1, c2, c3};
    fmt_ff <= i2s;
    wr(8'h27, pin);
    rd(8'h27, pin);
    for (int k = 0; k < 3; k++)
    begin
      wr(8'h28 + 8'(k), c[k]);
      rd(8'h28 + 8'(k), c[k]);
    end
    base = np;
    held = play_data_o;
    i_src.frame(i2s);
    repeat (30) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    for (int k = 0; k < 3; k++)
    begin
      check(8'(np[k] - base[k]), {7'h0, c[k][5]});
      if (c[k][5])
        check({3'h0, play_data_o[5*k +: 5]}, {3'h0, pin[k] ? ~c[k][4:0] : c[k][4:0]});
      else
        check({3'h0, play_data_o[5*k +: 5]}, {3'h0, held[5*k +: 5]});
    end
    @(posedge sys_clk_i);
  endtask
  task automatic t_reset_values();
    rd(8'h2a, 8'h02);
    rd(8'h28, 8'h20);
    rd(8'h29, 8'h21);
    rd(8'h27, 8'h00);
    rd(8'h30, 8'h00);
  endtask
  task automatic t_default_frame();
    run_frame(8'h20, 8'h21, 8'h02, 8'h00, 1'b0);
  endtask
  task automatic t_mid_reset();
    wr(8'h29, 8'h1f);
    rd(8'h29, 8'h1f);
    rst_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    rd(8'h29, 8'h21);
    rd(8'h28, 8'h20);
    rd(8'h2a, 8'h02);
  endtask
  task automatic t_tdm_sweep();
    for (int k = 0; k < 8; k++)
      run_frame(8'h20 | 8'(4*k), 8'h20 | 8'(4*k+3), 8'h20 | 8'(4*k+2), 8'h00, 1'b0);
  endtask
  task automatic t_i2s_sweep();
    for (int k = 0; k < 4; k++)
      run_frame(8'h20 | 8'(5*k), 8'h20 | 8'(16+5*k), 8'(32*(k%2)+17+4*k), 8'(5*k), 1'b1);
  endtask
  initial
  begin
    repeat (16) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    t_reset_values();
    t_default_frame();
    t_mid_reset();
    t_tdm_sweep();
    t_i2s_sweep();
    end_of_test();
  end
endmodule
